/* hdl/rtoc_pkg.sv */
package rtoc_pkg;

    localparam int unsigned RTOC_ADDR_W = 5;

    // register byte offsets
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_CTRL = 5'h00;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_CNT_LO = 5'h04;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_CNT_HI = 5'h08;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_RL_LO = 5'h0c;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_RL_HI = 5'h10;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_CKSEL = 5'h14;
    localparam logic [RTOC_ADDR_W-1:0] RTOC_OFF_IRQEN = 5'h18;

    localparam logic [7:0] RTOC_BYTE_MAX = 8'hff;
    localparam logic [7:0] RTOC_BYTE_ZERO = 8'h00;
    localparam logic [7:0] RTOC_BYTE_ONE = 8'h01;
    localparam logic [31:0] RTOC_WORD_ZERO = 32'h0000_0000;

    // divide ratios of the two slow clock sources
    localparam int unsigned RTOC_SYS_DIV = 12;
    localparam int unsigned RTOC_EXT_DIV = 8;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic hi_ovf_flag;
        logic lo_ovf_flag;
        logic lo_int_en;
        logic capture_en;
        logic split_mode;
        logic run_ctrl;
        logic unused;
        logic ext_clk_sel;
    } rtoc_ctrl_t;

    localparam rtoc_ctrl_t RTOC_CTRL_RST = 8'h00;

    // clock select register, bit 1 high byte, bit 0 low byte
    typedef struct packed {
        logic hi_sys_sel;
        logic lo_sys_sel;
    } rtoc_cksel_t;

    localparam rtoc_cksel_t RTOC_CKSEL_RST = 2'h0;

    // one-cycle tick pulses shared by the counting logic
    typedef struct packed {
        logic div_tick;
        logic ext_tick;
        logic ext_fall;
    } rtoc_ticks_t;

endpackage

/* hdl/rtoc_prescale.sv */
`timescale 1ns/10ps
module rtoc_prescale
    import rtoc_pkg::*;
#(
    parameter int unsigned DIV = RTOC_SYS_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic div_tick
);

    initial begin
        if (DIV < 2 || DIV > 256) begin
            $error("rtoc_prescale: DIV out of range");
        end
    end

    localparam logic [7:0] LAST = 8'(DIV - 1);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } rtoc_pre_state_t;

    rtoc_pre_state_t s_q;
    rtoc_pre_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = (s_q.cnt == LAST);
        s_d.cnt = (s_q.cnt == LAST) ? RTOC_BYTE_ZERO : s_q.cnt + RTOC_BYTE_ONE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign div_tick = s_q.tick;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DIV12_PERIOD: assert property (div_tick |-> ##12 div_tick)
        else $error("prescale tick period wrong");
    AST_DIV12_GAP: assert property (div_tick |=> !div_tick [*8])
        else $error("prescale tick too early");

endmodule // rtoc_prescale

/* hdl/rtoc_extsync.sv */
`timescale 1ns/10ps
module rtoc_extsync
    import rtoc_pkg::*;
#(
    parameter int unsigned DIV = RTOC_EXT_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_osc,
    output logic ext_tick,
    output logic ext_fall
);

    initial begin
        if (DIV != RTOC_EXT_DIV) begin
            $error("rtoc_extsync: only divide by 8 is served");
        end
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic [2:0] div;
        logic tick;
        logic fall;
    } rtoc_ext_state_t;

    rtoc_ext_state_t s_q;
    rtoc_ext_state_t s_d;
    logic rise;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = ext_osc;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        rise = s_q.sync2 & ~s_q.sync3;
        s_d.tick = 1'b0;
        s_d.fall = 1'b0;
        if (rise) begin
            s_d.div = s_q.div + 3'h1;
            // rising edge of divided clock advances the timer
            s_d.tick = (s_q.div == 3'h3);
            s_d.fall = (s_q.div == 3'h7);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ext_tick = s_q.tick;
    assign ext_fall = s_q.fall;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_EXT_EXCLUSIVE: assert property (ext_fall |-> !ext_tick ##1 !ext_tick)
        else $error("capture and tick coincide");

endmodule // rtoc_extsync

/* hdl/rtoc_timer.sv */
// Operation
// - low and high count bytes; split bit picks 16-bit or two 8-bit counters.
// - clock sources are core clock, core clock over 12, external over 8.
// - external clock is synchronised to the core clock first, then divided by 8.
// - 16-bit overflow from all ones reloads the pair and sets high flag.
// - 16-bit mode with interrupt enabled requests on every overflow.
// - with low-byte enable too, low byte wrap also requests an interrupt.
// - split mode reloads each byte from its own reload byte on overflow.
// - split mode run bit gates only high byte; low byte always counts.
// - per byte select bit picks core clock, else external select chooses source.
// - split mode high wrap sets high flag, low wrap sets low flag.
// - split mode requests on high overflow, either byte if low enable set.
// - hardware never clears flags; software clears and checks both.
// - capture event copies the 16-bit count into reload pair, sets high flag.
// - capture event is each falling edge of external clock over 8.
// - capture mode counts core clock or core over 12 per low select.
// - capture enable bit turns capture mode on when one.
// - 16-bit mode counts only while run bit is one, else holds.
`timescale 1ns/10ps
module rtoc_timer
    import rtoc_pkg::*;
#(
    parameter int unsigned SYS_DIV = RTOC_SYS_DIV,
    parameter int unsigned EXT_DIV = RTOC_EXT_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RTOC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_osc,
    output logic irq_req
);

    typedef struct packed {
        rtoc_ctrl_t ctrl;
        rtoc_cksel_t cksel;
        logic irq_en;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] rl_lo;
        logic [7:0] rl_hi;
        logic [31:0] rdata;
        logic err;
    } rtoc_state_t;

    rtoc_state_t s_q;
    rtoc_state_t s_d;
    rtoc_ticks_t tk;
    logic wr;
    logic setup;
    logic sel_tick_lo;
    logic sel_tick_hi;
    logic inc_lo;
    logic inc_hi;
    logic lo_full;
    logic hi_full;
    logic capture;
    logic set_hi;
    logic set_lo;

    rtoc_prescale #(
        .DIV(SYS_DIV)
    ) u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .div_tick(tk.div_tick)
    );

    rtoc_extsync #(
        .DIV(EXT_DIV)
    ) u_extsync (
        .pclk(pclk),
        .presetn(presetn),
        .ext_osc(ext_osc),
        .ext_tick(tk.ext_tick),
        .ext_fall(tk.ext_fall)
    );

    always_comb begin
        s_d = s_q;
        wr = psel & penable & pwrite;
        setup = psel & ~penable;
        lo_full = (s_q.cnt_lo == RTOC_BYTE_MAX);
        hi_full = (s_q.cnt_hi == RTOC_BYTE_MAX);

        sel_tick_lo = s_q.cksel.lo_sys_sel | (s_q.ctrl.ext_clk_sel ? tk.ext_tick : tk.div_tick);
        sel_tick_hi = s_q.cksel.hi_sys_sel | (s_q.ctrl.ext_clk_sel ? tk.ext_tick : tk.div_tick);
        if (s_q.ctrl.capture_en) begin
            sel_tick_lo = s_q.cksel.lo_sys_sel | tk.div_tick;
        end

        if (s_q.ctrl.split_mode) begin
            inc_lo = sel_tick_lo;
            inc_hi = s_q.ctrl.run_ctrl & sel_tick_hi;
        end else begin
            inc_lo = s_q.ctrl.run_ctrl & sel_tick_lo;
            inc_hi = inc_lo & lo_full;
        end

        if (inc_lo) begin
            if (!lo_full) begin
                s_d.cnt_lo = s_q.cnt_lo + RTOC_BYTE_ONE;
            end else if (s_q.ctrl.split_mode || hi_full) begin
                s_d.cnt_lo = s_q.rl_lo;
            end else begin
                s_d.cnt_lo = RTOC_BYTE_ZERO;
            end
        end
        if (inc_hi) begin
            s_d.cnt_hi = hi_full ? s_q.rl_hi : s_q.cnt_hi + RTOC_BYTE_ONE;
        end

        set_lo = inc_lo & lo_full;
        set_hi = inc_hi & hi_full;

        capture = s_q.ctrl.capture_en & tk.ext_fall;
        if (capture) begin
            s_d.rl_lo = s_q.cnt_lo;
            s_d.rl_hi = s_q.cnt_hi;
            set_hi = 1'b1;
        end

        if (wr) begin
            case (paddr)
                RTOC_OFF_CTRL: begin
                    s_d.ctrl = rtoc_ctrl_t'(pwdata[7:0]);
                    s_d.ctrl.unused = 1'b0;
                end
                RTOC_OFF_CNT_LO: s_d.cnt_lo = pwdata[7:0];
                RTOC_OFF_CNT_HI: s_d.cnt_hi = pwdata[7:0];
                RTOC_OFF_RL_LO: s_d.rl_lo = pwdata[7:0];
                RTOC_OFF_RL_HI: s_d.rl_hi = pwdata[7:0];
                RTOC_OFF_CKSEL: s_d.cksel = rtoc_cksel_t'(pwdata[1:0]);
                RTOC_OFF_IRQEN: s_d.irq_en = pwdata[0];
                default: s_d.err = s_q.err;
            endcase
        end

        if (set_hi) begin
            s_d.ctrl.hi_ovf_flag = 1'b1;
        end
        if (set_lo) begin
            s_d.ctrl.lo_ovf_flag = 1'b1;
        end

        // read data and error settle in the setup cycle, so pready never waits
        if (setup) begin
            s_d.err = 1'b0;
            case (paddr)
                RTOC_OFF_CTRL: s_d.rdata = {24'h00_0000, s_q.ctrl};
                RTOC_OFF_CNT_LO: s_d.rdata = {24'h00_0000, s_q.cnt_lo};
                RTOC_OFF_CNT_HI: s_d.rdata = {24'h00_0000, s_q.cnt_hi};
                RTOC_OFF_RL_LO: s_d.rdata = {24'h00_0000, s_q.rl_lo};
                RTOC_OFF_RL_HI: s_d.rdata = {24'h00_0000, s_q.rl_hi};
                RTOC_OFF_CKSEL: s_d.rdata = {30'h0000_0000, s_q.cksel};
                RTOC_OFF_IRQEN: s_d.rdata = {31'h0000_0000, s_q.irq_en};
                default: begin
                    s_d.rdata = RTOC_WORD_ZERO;
                    s_d.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s_q.err;

    assign irq_req = s_q.irq_en &
        (s_q.ctrl.hi_ovf_flag | (s_q.ctrl.lo_int_en & s_q.ctrl.lo_ovf_flag));

    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic wr_rl;
    assign wr_ctrl = wr && paddr == RTOC_OFF_CTRL;
    assign wr_lo = wr && paddr == RTOC_OFF_CNT_LO;
    assign wr_hi = wr && paddr == RTOC_OFF_CNT_HI;
    assign wr_rl = wr && (paddr == RTOC_OFF_RL_LO || paddr == RTOC_OFF_RL_HI);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_OVF16_RELOAD: assert property (
        !s_q.ctrl.split_mode && inc_lo && lo_full && hi_full && !wr_lo && !wr_hi && !wr_rl
        |=> s_q.cnt_lo == $past(s_q.rl_lo) && s_q.cnt_hi == $past(s_q.rl_hi)
            && s_q.ctrl.hi_ovf_flag)
        else $error("16-bit overflow did not reload");
    AST_HOLD_STOPPED: assert property (
        !s_q.ctrl.split_mode && !s_q.ctrl.run_ctrl && !wr
        |=> $stable(s_q.cnt_lo) && $stable(s_q.cnt_hi))
        else $error("stopped counter moved");
    AST_SPLIT_LOW_FREE: assert property (
        s_q.ctrl.split_mode && !s_q.ctrl.run_ctrl && s_q.cksel.lo_sys_sel && !lo_full
        && !wr_lo && !wr_hi
        |=> s_q.cnt_lo == $past(s_q.cnt_lo) + RTOC_BYTE_ONE && $stable(s_q.cnt_hi))
        else $error("split low byte not free running");
    AST_SPLIT_RELOAD: assert property (
        s_q.ctrl.split_mode && inc_lo && lo_full && !hi_full && !wr_lo && !wr_rl
        |=> s_q.cnt_lo == $past(s_q.rl_lo) && s_q.ctrl.lo_ovf_flag)
        else $error("split low byte reload wrong");
    AST_SPLIT_HI_FLAG: assert property (
        s_q.ctrl.split_mode && inc_hi && hi_full && !wr_ctrl |=> s_q.ctrl.hi_ovf_flag)
        else $error("split high overflow flag missing");
    AST_FLAG_STICKY: assert property (
        s_q.ctrl.hi_ovf_flag && !wr_ctrl |=> s_q.ctrl.hi_ovf_flag [*1])
        else $error("hardware cleared high flag");
    AST_CAPTURE: assert property (
        capture && !wr_rl && !wr_ctrl
        |=> s_q.rl_hi == $past(s_q.cnt_hi) && s_q.rl_lo == $past(s_q.cnt_lo)
            && s_q.ctrl.hi_ovf_flag)
        else $error("capture did not copy count");
    AST_WRITE_DIRECT: assert property (
        wr_lo |=> s_q.cnt_lo == 8'($past(pwdata)))
        else $error("count write lost");
    AST_IRQ_LOW: assert property (
        s_q.irq_en && s_q.ctrl.lo_int_en && set_lo |=> irq_req)
        else $error("low byte interrupt missing");
    AST_IRQ_HI: assert property (
        s_q.irq_en && set_hi && !wr_ctrl |=> irq_req ##1 (irq_req || $past(wr_ctrl)))
        else $error("overflow interrupt missing");

    COV_OVF16: cover property (!s_q.ctrl.split_mode && set_hi);
    COV_SPLIT_LO: cover property (s_q.ctrl.split_mode && set_lo && !s_q.ctrl.run_ctrl);
    // captures sit one divided external period apart, so the window spans more than that
    COV_CAPTURE: cover property (capture ##[1:80] capture);
    COV_SET_VS_CLEAR: cover property (set_hi && wr_ctrl && !pwdata[7]);

endmodule // rtoc_timer

/* test/rtoc_osc_model.sv */
`timescale 1ns/10ps
module rtoc_osc_model #(
    parameter real HALF_NS = 100.0
) (
    output logic ext_osc
);
    // slow capture clock: eight core periods per cycle
    initial begin
        ext_osc = 1'b0;
        // odd start offset keeps edges away from pclk edges
        #7;
        forever begin
            #HALF_NS ext_osc = ~ext_osc;
        end
    end
endmodule // rtoc_osc_model

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import rtoc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [RTOC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_osc;
    logic irq_req;
    logic [31:0] rdata;
    logic rerr;
    logic [15:0] cap_a;
    int bad_count = 0;
    int n_checks = 0;
    logic [7:0] tab_ctl [5] = '{8'h80, 8'h40, 8'h60, 8'h80, 8'h00};
    logic tab_en [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic tab_irq [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #12.5 pclk = ~pclk;

    rtoc_timer i_rtoc_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_osc(ext_osc), .irq_req(irq_req)
    );
    rtoc_osc_model i_rtoc_osc_model (.ext_osc(ext_osc));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer; pready is polled under a bound, never assumed
    task automatic apb(input logic wr, input logic [RTOC_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [RTOC_ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [RTOC_ADDR_W-1:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_flag(input int b);
        int n;
        n = 0;
        rdata = 32'h0000_0000;
        while (rdata[b] !== 1'b1 && n < 1000) begin
            rd(RTOC_OFF_CTRL);
            n++;
        end
        if (rdata[b] !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        wr(RTOC_OFF_CNT_LO, lo);
        wr(RTOC_OFF_CNT_HI, hi);
    endtask

    // count difference between two successive captures, left in cap_a
    task automatic capture_gap(input logic [7:0] ctl);
        logic [15:0] first;
        load(8'h00, 8'h00);
        wr(RTOC_OFF_CTRL, ctl);
        wait_flag(7);
        rd(RTOC_OFF_RL_LO);
        first[7:0] = rdata[7:0];
        rd(RTOC_OFF_RL_HI);
        first[15:8] = rdata[7:0];
        wr(RTOC_OFF_CTRL, ctl);
        wait_flag(7);
        rd(RTOC_OFF_RL_LO);
        cap_a[7:0] = rdata[7:0];
        rd(RTOC_OFF_RL_HI);
        cap_a[15:8] = rdata[7:0];
        cap_a = cap_a - first;
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            rd(5'(a));
            chk("reset value", rdata, 32'h0000_0000);
            chk("mapped err", {31'h0, rerr}, 32'h0000_0000);
        end
        rd(5'h1c);
        chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
        load(8'h00, 8'hff);
        wr(RTOC_OFF_RL_LO, 8'h00);
        wr(RTOC_OFF_RL_HI, 8'hff);
        wr(RTOC_OFF_CKSEL, 8'h03);
        repeat (10) @(posedge pclk);
        rd(RTOC_OFF_CNT_HI);
        chk("held count", rdata, 32'h0000_00ff);
        rd(RTOC_OFF_CNT_LO);
        chk("written count", rdata, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(RTOC_OFF_IRQEN, {7'h00, tab_en[i]});
            wr(RTOC_OFF_CTRL, tab_ctl[i]);
            @(posedge pclk);
            chk("irq by flags", {31'h0, irq_req}, {31'h0, tab_irq[i]});
        end
        wr(RTOC_OFF_CTRL, 8'h80);
        repeat (100) @(posedge pclk);
        rd(RTOC_OFF_CTRL);
        chk("flag kept", rdata, 32'h0000_0080);
        wr(RTOC_OFF_CTRL, 8'h04);
        wait_flag(7);
        chk("both flags", {30'h0, rdata[7:6]}, 32'h0000_0003);
        chk("irq overflow", {31'h0, irq_req}, 32'h0000_0001);
        wr(RTOC_OFF_CTRL, 8'h00);
        rd(RTOC_OFF_CNT_HI);
        chk("reloaded high", rdata, 32'h0000_00ff);
        load(8'h00, 8'h05);
        wr(RTOC_OFF_RL_LO, 8'hf0);
        wr(RTOC_OFF_CTRL, 8'h08);
        wait_flag(6);
        chk("no high flag", {31'h0, rdata[7]}, 32'h0000_0000);
        rd(RTOC_OFF_CNT_HI);
        chk("high gated", rdata, 32'h0000_0005);
        rd(RTOC_OFF_CNT_LO);
        chk("low reload", {31'h0, rdata[7:0] >= 8'hf0}, 32'h0000_0001);
        wr(RTOC_OFF_RL_HI, 8'h80);
        wr(RTOC_OFF_CTRL, 8'h0c);
        wait_flag(7);
        wr(RTOC_OFF_CTRL, 8'h08);
        rd(RTOC_OFF_CNT_HI);
        chk("high reload", {31'h0, rdata[7:0] >= 8'h80}, 32'h0000_0001);
        // prescaler phase is unknown, so one tick either way is allowed
        wr(RTOC_OFF_CKSEL, 8'h00);
        wr(RTOC_OFF_CTRL, 8'h00);
        load(8'h00, 8'h00);
        wr(RTOC_OFF_CTRL, 8'h04);
        repeat (240) @(posedge pclk);
        wr(RTOC_OFF_CTRL, 8'h00);
        rd(RTOC_OFF_CNT_LO);
        chk("div12 rate", {31'h0, rdata >= 19 && rdata <= 21}, 32'h0000_0001);
        load(8'h00, 8'h00);
        wr(RTOC_OFF_CTRL, 8'h05);
        repeat (640) @(posedge pclk);
        wr(RTOC_OFF_CTRL, 8'h01);
        rd(RTOC_OFF_CNT_LO);
        chk("ext8 rate", {31'h0, rdata >= 9 && rdata <= 11}, 32'h0000_0001);
        rd(RTOC_OFF_RL_LO);
        chk("no capture", rdata, 32'h0000_00f0);
        wr(RTOC_OFF_CKSEL, 8'h01);
        capture_gap(8'h14);
        chk("capture gap", {16'h0000, cap_a}, 32'h0000_0040);
        // external select set, yet capture mode must count core over twelve
        wr(RTOC_OFF_CKSEL, 8'h00);
        capture_gap(8'h15);
        chk("capture div12", {31'h0, cap_a >= 5 && cap_a <= 6}, 32'h0000_0001);
        stop_test();
    end
endmodule // tb_top
